/* File: hdl/scc_ctrl.sv */
`timescale 1ns/100ps
module scc_ctrl
   import scc_pkg::*;
(
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // core flags and bit tick
   input  wire scc_core_flags_type core_flags,
   input  wire logic        bit_tick,
   // serial pins
   input  wire logic        rxd_pin,
   output logic             txd_out,
   output logic             txd_oe,
   // control outputs
   output logic             irq_q,
   output logic             rx_enable_q,
   output logic             infrared_on_q,
   output logic [5:0]       ir_pulse_q
);
   // registers
   logic [7:0]        alt_irq_enables_q;
   logic [7:0]        alt_feature_ctrl_q;
   logic [7:0]        main_ctrl_q;
   logic [7:0]        cfg_q;
   logic              rx_active_edge_flag_q;
   logic              biterr_flag_q;
   logic              brkdet_flag_q;
   logic              rx_s1_q;
   logic              rx_s2_q;
   logic              rx_s3_q;
   logic [3:0]        tick_q;
   logic [3:0]        bitcnt_q;
   logic [3:0]        zcnt_q;
   scc_tx_state_type  tx_state_q;
   logic              preamble_pend_q;
   logic              break_pend_q;
   logic              tx_bit;
   logic              wr_ok;
   logic              rd_ok;
   logic              alt_ok;
   logic              edge_seen;
   logic              berr_sample;
   logic [3:0]        brk_len;
   logic              irq_d;

   wire logic edge_irq_en      = alt_irq_enables_q[B_EDGE];
   wire logic biterr_irq_en    = alt_irq_enables_q[B_BERR];
   wire logic brkdet_irq_en    = alt_irq_enables_q[B_BKD];
   wire logic infrared_on      = alt_feature_ctrl_q[7];
   wire logic [1:0] ir_pulse_width_sel  = alt_feature_ctrl_q[6:5];
   wire logic [1:0] biterr_sample_mode  = alt_feature_ctrl_q[2:1];
   wire logic brkdet_circuit_on = alt_feature_ctrl_q[0];
   wire logic tx_empty_irq_en  = main_ctrl_q[7];
   wire logic tx_done_irq_en   = main_ctrl_q[6];
   wire logic rx_full_irq_en   = main_ctrl_q[5];
   wire logic line_quiet_irq_en = main_ctrl_q[4];
   wire logic tx_enable        = main_ctrl_q[3];
   wire logic rx_enable        = main_ctrl_q[2];
   wire logic rx_standby       = main_ctrl_q[1];
   wire logic break_send       = main_ctrl_q[0];
   wire logic alt_map_select   = cfg_q[B_ALT_MAP];
   wire logic long_break_sel   = cfg_q[B_BRK_LONG];
   wire logic rx_polarity      = cfg_q[B_RX_POLARITY];
   wire logic len9             = cfg_q[B_LEN9];

   function automatic logic [5:0] pulse_width(input logic [1:0] sel);
      unique case (sel)
         TNP_1_4:  pulse_width = W_1_4;
         TNP_1_32: pulse_width = W_1_32;
         TNP_1_16: pulse_width = W_1_16;
         TNP_3_16: pulse_width = W_3_16;
      endcase
   endfunction
   assign wr_ok  = psel && penable && pwrite;
   assign rd_ok  = psel && !pwrite;
   assign alt_ok = alt_map_select;
   // zero-wait slave; unmapped or hidden addresses answer pslverr
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !(paddr == ADDR_STATUS || paddr == ADDR_MAIN ||
                    paddr == ADDR_CFG || ((paddr == ADDR_ALT_IRQ ||
                    paddr == ADDR_ALT_FEAT) && alt_ok));
      end
   end

   // writes land on the access edge, the one cycle that pready is high
   wire logic wr_now = wr_ok && pready;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         alt_irq_enables_q  <= RST_ZERO;
         alt_feature_ctrl_q <= RST_ZERO;
         cfg_q              <= RST_ZERO;
      end
      else if (wr_now)
      begin
         if (paddr == ADDR_ALT_IRQ && alt_ok)
            alt_irq_enables_q <= pwdata[7:0] & 8'h83;
         if (paddr == ADDR_ALT_FEAT && alt_ok)
            alt_feature_ctrl_q <= pwdata[7:0] & 8'he7;
         if (paddr == ADDR_CFG)
            cfg_q <= pwdata[7:0] & 8'hf0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         main_ctrl_q <= RST_ZERO;
      else if (wr_now && paddr == ADDR_MAIN)
         main_ctrl_q <= pwdata[7:0];
      else if (core_flags.wakeup)
         main_ctrl_q[1] <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_ok && !penable)
      begin
         prdata <= 32'h0000_0000;
         unique case (paddr)
            ADDR_STATUS:   prdata[7:0] <= {rx_active_edge_flag_q, 5'h00, biterr_flag_q,
                                           brkdet_flag_q};
            ADDR_ALT_IRQ:  prdata[7:0] <= alt_ok ? alt_irq_enables_q : RST_ZERO;
            ADDR_ALT_FEAT: prdata[7:0] <= alt_ok ? alt_feature_ctrl_q : RST_ZERO;
            ADDR_MAIN:     prdata[7:0] <= main_ctrl_q;
            ADDR_CFG:      prdata[7:0] <= cfg_q;
            default:       prdata[7:0] <= RST_ZERO;
         endcase
      end
   end

   // receive pin synchroniser
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
         rx_s3_q <= 1'b1;
      end
      else
      begin
         rx_s1_q <= rxd_pin;
         rx_s2_q <= rx_s1_q;
         rx_s3_q <= rx_s2_q;
      end
   end

   assign edge_seen = rx_polarity ? (rx_s2_q && !rx_s3_q) : (!rx_s2_q && rx_s3_q);
   // write-one-to-clear flags, cleared only while the alt map is set; a set in the same cycle wins
   wire logic st_clr = wr_now && paddr == ADDR_STATUS && alt_ok;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rx_active_edge_flag_q <= 1'b0;
      else if (edge_seen)
         rx_active_edge_flag_q <= 1'b1;
      else if (st_clr && pwdata[B_EDGE])
         rx_active_edge_flag_q <= 1'b0;
   end

   // tick counter, 16 ticks per bit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tick_q <= 4'h0;
      else if (bit_tick)
         tick_q <= tick_q + 4'h1;
   end
   wire logic bit_end = bit_tick && tick_q == TICK_LAST;
   always_comb
   begin
      berr_sample = 1'b0;
      if (bit_tick && tx_enable)
      begin
         if (biterr_sample_mode == BEM_T9)
            berr_sample = tick_q == TICK_S9;
         else if (biterr_sample_mode == BEM_T13)
            berr_sample = tick_q == TICK_S13;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         biterr_flag_q <= 1'b0;
      else if (berr_sample && rx_s2_q != tx_bit)
         biterr_flag_q <= 1'b1;
      else if (st_clr && pwdata[B_BERR])
         biterr_flag_q <= 1'b0;
   end

   assign brk_len = long_break_sel ? (len9 ? BRK_BITS_L9 : BRK_BITS_L8)
                                   : (len9 ? BRK_BITS_9 : BRK_BITS_8);

   // zero-bit run counter for break detection
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         zcnt_q <= 4'h0;
      else if (bit_end)
         zcnt_q <= rx_s2_q ? 4'h0 : (zcnt_q == TICK_LAST ? zcnt_q : zcnt_q + 4'h1);
   end
   // break detect when enabled; an all-zero character stops one bit short, or four bits short with long breaks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         brkdet_flag_q <= 1'b0;
      else if (brkdet_circuit_on && bit_end && !rx_s2_q && zcnt_q == brk_len - 4'h1)
         brkdet_flag_q <= 1'b1;
      else if (st_clr && pwdata[B_BKD])
         brkdet_flag_q <= 1'b0;
   end

   // transmit sequencer: preamble and break characters
   // enable written from off queues preamble
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         preamble_pend_q <= 1'b0;
      else if (wr_now && paddr == ADDR_MAIN && pwdata[3] && !tx_enable)
         preamble_pend_q <= 1'b1;
      else if (tx_state_q == TX_PREAMBLE)
         preamble_pend_q <= 1'b0;
   end
   // break bit cleared before the next bit boundary still counts
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         break_pend_q <= 1'b0;
      else if (wr_now && paddr == ADDR_MAIN && pwdata[0])
         break_pend_q <= 1'b1;
      else if (tx_state_q == TX_BREAK || !tx_enable)
         break_pend_q <= 1'b0;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_state_q <= TX_IDLE;
         bitcnt_q   <= 4'h0;
      end
      else if (!tx_enable)
      begin
         tx_state_q <= TX_IDLE;
         bitcnt_q   <= 4'h0;
      end
      else if (bit_end)
      begin
         unique case (tx_state_q)
            TX_IDLE:
            begin
               bitcnt_q <= 4'h0;
               if (preamble_pend_q)
                  tx_state_q <= TX_PREAMBLE;
               else if (break_send || break_pend_q)
                  tx_state_q <= TX_BREAK;
            end
            TX_PREAMBLE:
            begin
               bitcnt_q <= bitcnt_q + 4'h1;
               if (bitcnt_q == FRAME_BITS - 4'h1)
                  tx_state_q <= TX_IDLE;
            end
            TX_BREAK:
            begin
               bitcnt_q <= bitcnt_q + 4'h1;
               if (bitcnt_q == brk_len - 4'h1)
               begin
                  bitcnt_q <= 4'h0;
                  tx_state_q <= break_send ? TX_BREAK : TX_IDLE;
               end
            end
            default: tx_state_q <= TX_IDLE;
         endcase
      end
   end
   assign tx_bit = tx_state_q != TX_BREAK;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         txd_out <= 1'b1;
         txd_oe  <= 1'b0;
      end
      else
      begin
         txd_out <= tx_bit;
         txd_oe  <= tx_enable;
      end
   end

   always_comb
   begin
      irq_d = 1'b0;
      irq_d = irq_d | (rx_active_edge_flag_q & edge_irq_en);
      irq_d = irq_d | (biterr_flag_q & biterr_irq_en);
      irq_d = irq_d | (brkdet_flag_q & brkdet_irq_en);
      irq_d = irq_d | (core_flags.tx_empty & tx_empty_irq_en);
      irq_d = irq_d | (core_flags.tx_done & tx_done_irq_en);
      irq_d = irq_d | ((core_flags.rx_full | core_flags.overrun) & rx_full_irq_en & !rx_standby);
      irq_d = irq_d | (core_flags.line_quiet & line_quiet_irq_en & !rx_standby);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_q         <= 1'b0;
         rx_enable_q   <= 1'b0;
         infrared_on_q <= 1'b0;
         ir_pulse_q    <= W_3_16;
      end
      else
      begin
         irq_q         <= irq_d;
         rx_enable_q   <= rx_enable;
         infrared_on_q <= infrared_on;
         ir_pulse_q    <= pulse_width(ir_pulse_width_sel);
      end
   end
   AST_MAIN_RESET: assert property (@(posedge pclk) $rose(presetn) |-> main_ctrl_q == RST_ZERO)
      else $error("main control not zero after reset");
   AST_ALT_HIDDEN: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_now && paddr == ADDR_ALT_IRQ && !alt_map_select) |=> $stable(alt_irq_enables_q))
      else $error("alt register written while hidden");
   AST_EDGE_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_active_edge_flag_q && edge_irq_en) |=> irq_q)
      else $error("edge request missing");
   AST_BERR_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      (biterr_flag_q && alt_irq_enables_q[1]) |=> irq_q)
      else $error("bit error request missing");
   AST_BKD_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      (brkdet_flag_q && alt_irq_enables_q[0]) |=> irq_q)
      else $error("break detect request missing");
   AST_TXE_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      (core_flags.tx_empty && main_ctrl_q[7]) |=> irq_q)
      else $error("transmit empty request missing");
   AST_NO_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      (alt_irq_enables_q == RST_ZERO && main_ctrl_q[7:4] == 4'h0) |=> !irq_q)
      else $error("spurious request");
   AST_TX_PIN: assert property (@(posedge pclk) disable iff (!presetn)
      tx_enable |=> txd_oe)
      else $error("transmit pin not driven");
   AST_BRK_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_state_q == TX_BREAK) |=> !txd_out)
      else $error("break not driven low");
   AST_STANDBY_CLR: assert property (@(posedge pclk) disable iff (!presetn)
      (core_flags.wakeup && !(wr_now && paddr == ADDR_MAIN)) |=> !main_ctrl_q[1])
      else $error("standby not cleared on wakeup");
endmodule

/* File: hdl/scc_pkg.sv */
// Functional notes
// - alt registers reachable only when alt map set
// - edge enable gates active edge flag
// - alt enable bit 1 gates bit error
// - alt enable bit 0 gates break detect
// - feature bit 7 switches infrared on
// - pulse select sets infrared pulse width
// - bit error mode picks sample tick
// - feature bit 0 enables break detect
// - main control always accessible, resets zero
// - bit 7 gates transmit empty request
// - bit 6 gates transmit done request
// - bit 5 gates receive full or overrun
// - bit 4 gates idle line request
// - bit 3 enables transmitter, owns pin
// - transmitter enable queues idle preamble
// - bit 2 enables receiver
// - bit 1 standby, hardware clears on wakeup
// - toggled break sends exactly one break
// - held break sends breaks back to back
// - length select sets break length; preamble frame fixed at ten bits
// - bit error flag on sampled mismatch
// - break detect flag on received break
// - active edge by receive polarity
package scc_pkg;
   localparam logic [7:0] ADDR_STATUS   = 8'h00;
   localparam logic [7:0] ADDR_ALT_IRQ  = 8'h04;
   localparam logic [7:0] ADDR_ALT_FEAT = 8'h08;
   localparam logic [7:0] ADDR_MAIN     = 8'h0c;
   localparam logic [7:0] ADDR_CFG      = 8'h10;
   localparam logic [7:0] RST_ZERO      = 8'h00;
   localparam int         B_ALT_MAP     = 7;
   localparam int         B_BRK_LONG    = 6;
   localparam int         B_RX_POLARITY       = 5;
   localparam int         B_LEN9        = 4;
   localparam int         B_EDGE        = 7;
   localparam int         B_BERR        = 1;
   localparam int         B_BKD         = 0;
   localparam logic [3:0] BRK_BITS_8    = 4'ha;
   localparam logic [3:0] BRK_BITS_9    = 4'hb;
   localparam logic [3:0] BRK_BITS_L8   = 4'hd;
   localparam logic [3:0] BRK_BITS_L9   = 4'he;
   localparam logic [3:0] FRAME_BITS    = 4'ha;
   localparam logic [3:0] TICK_LAST     = 4'hf;
   localparam logic [3:0] TICK_S9       = 4'h8;
   localparam logic [3:0] TICK_S13      = 4'hc;
   localparam logic [1:0] BEM_OFF       = 2'h0;
   localparam logic [1:0] BEM_T9        = 2'h1;
   localparam logic [1:0] BEM_T13       = 2'h2;
   localparam logic [1:0] TNP_3_16      = 2'h0;
   localparam logic [1:0] TNP_1_16      = 2'h1;
   localparam logic [1:0] TNP_1_32      = 2'h2;
   localparam logic [1:0] TNP_1_4       = 2'h3;
   localparam logic [5:0] W_3_16        = 6'h06;
   localparam logic [5:0] W_1_16        = 6'h02;
   localparam logic [5:0] W_1_32        = 6'h01;
   localparam logic [5:0] W_1_4         = 6'h08;

   typedef enum logic [1:0] {
      TX_IDLE     = 2'b00,
      TX_PREAMBLE = 2'b01,
      TX_BREAK    = 2'b10
   } scc_tx_state_type;

   typedef struct packed {
      logic tx_empty;
      logic tx_done;
      logic rx_full;
      logic overrun;
      logic line_quiet;
      logic wakeup;
   } scc_core_flags_type;
endpackage

/* File: verification/scc_remote_model.sv */
`timescale 1ns/100ps
module scc_remote_model
(
   // clock
   input  wire logic pclk,
   // line from the block
   input  wire logic txd_out,
   input  wire logic txd_oe,
   // bench stimulus
   input  wire logic line_level,
   input  wire logic echo_inverted,
   // line into the block
   output logic      rxd_pin,
   // low-run measurements
   output int        last_run,
   output int        run_count,
   output int        zero_total
);
   int   zero_run;
   logic line_seen;
   // released transmitter reads high on the pulled-up line
   assign line_seen = txd_oe ? txd_out : 1'b1;
   // inverted echo makes every transmitted bit a mismatch
   assign rxd_pin = echo_inverted ? ~line_seen : line_level;
   initial
   begin
      zero_run = 0;
      last_run = 0;
      run_count = 0;
      zero_total = 0;
   end
   always @(posedge pclk)
   begin
      if (line_seen == 1'b0)
      begin
         zero_run <= zero_run + 1;
         zero_total <= zero_total + 1;
      end
      else if (zero_run != 0)
      begin
         last_run <= zero_run;
         run_count <= run_count + 1;
         zero_run <= 0;
      end
   end
endmodule

/* File: verification/tb_scc_ctrl.sv */
`timescale 1ns/100ps
module tb_scc_ctrl
   import scc_pkg::*;
();
   logic               pclk, presetn, psel, penable, pwrite, bit_tick, rxd_pin;
   logic               pready, pslverr, txd_out, txd_oe, irq_q, rx_enable_q;
   logic               infrared_on_q, err, line_level, echo_inverted;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, rd;
   logic [5:0]         ir_pulse_q;
   scc_core_flags_type core_flags;
   int                 miscompares, check_count, cycles, last_run, run_count, zero_total;
   int                 n;
   logic [5:0]         w_tab [4] = '{W_3_16, W_1_16, W_1_32, W_1_4};
   logic [7:0]         en_tab [5] = '{8'h80, 8'h40, 8'h20, 8'h20, 8'h10};
   logic [7:0]         cfg_tab [4] = '{8'h80, 8'h90, 8'hc0, 8'hd0};
   int                 brk_tab [4] = '{10, 11, 13, 14};

   scc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .core_flags(core_flags), .bit_tick(bit_tick), .rxd_pin(rxd_pin),
      .txd_out(txd_out), .txd_oe(txd_oe), .irq_q(irq_q), .rx_enable_q(rx_enable_q),
      .infrared_on_q(infrared_on_q), .ir_pulse_q(ir_pulse_q));
   scc_remote_model remote (.pclk(pclk), .txd_out(txd_out), .txd_oe(txd_oe),
      .line_level(line_level), .echo_inverted(echo_inverted), .rxd_pin(rxd_pin),
      .last_run(last_run), .run_count(run_count), .zero_total(zero_total));

   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // sixteen ticks per bit, one tick every other cycle: 32 cycles a bit
   always @(posedge pclk)
   begin
      bit_tick <= ~bit_tick;
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         miscompares++;
         tally_and_finish();
      end
   end

   task tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk_reg(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t value %h expected %h", $time, got, exp);
      end
   endtask
   task chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t bit %b expected %b", $time, got, exp);
      end
   endtask
   // request held until pready is seen high at a rising edge
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      chk_bit(pready, 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
      apb(a, 1'b1, d);
      chk_bit(err, exp_err);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      chk_reg(rd, exp);
   endtask
   task settle;
      repeat (3) @(posedge pclk);
   endtask
   task wait_bits(input int b);
      repeat (b * 32) @(posedge pclk);
   endtask
   task brk;
      wr(ADDR_MAIN, 32'h0d, 1'b0);
      wr(ADDR_MAIN, 32'h0c, 1'b0);
      wait_bits(24);
   endtask

   initial
   begin
      {psel, penable, pwrite, bit_tick, echo_inverted, presetn} = '0;
      {paddr, pwdata, core_flags, cycles, miscompares, check_count} = '0;
      line_level = 1'b1;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk_bit(txd_out, 1'b1);
      chk_bit(txd_oe, 1'b0);
      chk_bit(rx_enable_q, 1'b0);
      rdc(ADDR_MAIN, 32'h0);
      wr(ADDR_ALT_IRQ, 32'h83, 1'b1);
      rdc(ADDR_ALT_IRQ, 32'h0);
      wr(ADDR_CFG, 32'h80, 1'b0);
      wr(ADDR_ALT_IRQ, 32'h83, 1'b0);
      rdc(ADDR_ALT_IRQ, 32'h83);
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_ALT_FEAT, 32'h80 | (i << 5), 1'b0);
         settle();
         chk_bit(infrared_on_q, 1'b1);
         chk_reg({26'h0, ir_pulse_q}, {26'h0, w_tab[i]});
      end
      wr(ADDR_ALT_FEAT, 32'h0, 1'b0);
      settle();
      chk_bit(infrared_on_q, 1'b0);
      wr(ADDR_ALT_IRQ, 32'h0, 1'b0);
      $display("test registers done");
      for (int i = 0; i < 5; i++)
      begin
         wr(ADDR_MAIN, 32'h0, 1'b0);
         core_flags <= 6'b100000 >> i;
         settle();
         chk_bit(irq_q, 1'b0);
         wr(ADDR_MAIN, {24'h0, en_tab[i]}, 1'b0);
         settle();
         chk_bit(irq_q, 1'b1);
      end
      wr(ADDR_MAIN, 32'h22, 1'b0);
      core_flags <= 6'b001000;
      settle();
      chk_bit(irq_q, 1'b0);
      core_flags <= 6'b001001;
      @(posedge pclk);
      core_flags <= 6'b001000;
      settle();
      rdc(ADDR_MAIN, 32'h20);
      chk_bit(irq_q, 1'b1);
      core_flags <= '0;
      $display("test interrupt gating done");
      wr(ADDR_MAIN, 32'h0c, 1'b0);
      settle();
      chk_bit(rx_enable_q, 1'b1);
      chk_bit(txd_oe, 1'b1);
      chk_bit(txd_out, 1'b1);
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_CFG, {24'h0, cfg_tab[i]}, 1'b0);
         n = run_count;
         brk();
         chk_reg(run_count, n + 1);
         chk_reg((last_run + 16) / 32, brk_tab[i]);
      end
      n = zero_total;
      wr(ADDR_MAIN, 32'h0d, 1'b0);
      wait_bits(40);
      wr(ADDR_MAIN, 32'h0c, 1'b0);
      wait_bits(20);
      chk_bit(zero_total - n >= 27 * 32, 1'b1);
      chk_bit(last_run >= 27 * 32, 1'b1);
      wr(ADDR_CFG, 32'h80, 1'b0);
      $display("test transmitter done");
      wr(ADDR_ALT_IRQ, 32'h02, 1'b0);
      for (int m = 0; m < 4; m++)
      begin
         wr(ADDR_ALT_FEAT, m << 1, 1'b0);
         wr(ADDR_STATUS, 32'hff, 1'b0);
         echo_inverted <= 1'b1;
         brk();
         echo_inverted <= 1'b0;
         wait_bits(2);
         apb(ADDR_STATUS, 1'b0, 32'h0);
         chk_bit(rd[1], m == 1 || m == 2);
         chk_bit(irq_q, m == 1 || m == 2);
      end
      wr(ADDR_ALT_IRQ, 32'h01, 1'b0);
      for (int e = 0; e < 2; e++)
      begin
         wr(ADDR_ALT_FEAT, e, 1'b0);
         wr(ADDR_STATUS, 32'hff, 1'b0);
         line_level <= 1'b0;
         wait_bits(16);
         line_level <= 1'b1;
         wait_bits(2);
         apb(ADDR_STATUS, 1'b0, 32'h0);
         chk_bit(rd[0], e);
         chk_bit(irq_q, e);
      end
      $display("test error and break detect done");
      wr(ADDR_ALT_IRQ, 32'h80, 1'b0);
      wr(ADDR_ALT_FEAT, 32'h0, 1'b0);
      for (int p = 0; p < 2; p++)
      begin
         wr(ADDR_CFG, 32'h80 | (p << 5), 1'b0);
         line_level <= ~p[0];
         wait_bits(1);
         wr(ADDR_STATUS, 32'hff, 1'b0);
         rdc(ADDR_STATUS, 32'h0);
         line_level <= p[0];
         repeat (8) @(posedge pclk);
         rdc(ADDR_STATUS, 32'h80);
         settle();
         chk_bit(irq_q, 1'b1);
      end
      wr(ADDR_ALT_IRQ, 32'h0, 1'b0);
      settle();
      chk_bit(irq_q, 1'b0);
      $display("test active edge done");
      tally_and_finish();
   end
endmodule
